/* File: wdt_exec_defs.svh */
// offsets, opcode fields, reset values and widths for the exec block
`ifndef WDT_EXEC_DEFS_SVH
`define WDT_EXEC_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets on the apb side
// ---------------------------------------------------------------
`define OFS_INSTR      12'h000
`define OFS_WREG       12'h004
`define OFS_STATUS     12'h008
`define OFS_WDT        12'h00c
// file window: 0x200..0x3fc, one byte per aligned word
`define FILE_SEL       3'h1
`define FILE_SEL_HI    11
`define FILE_SEL_LO    9
`define FILE_IDX_HI    8
`define FILE_IDX_LO    2

// ---------------------------------------------------------------
// instruction encodings and fields
// ---------------------------------------------------------------
`define OP_WDT_CLR     14'h0064
`define OP_CPL_FILE    6'h09
`define OP_DEC_FILE    6'h03
`define OPC_HI         13
`define OPC_LO         8
`define DEST_BIT       7
`define FADDR_HI       6
`define FADDR_LO       0

// ---------------------------------------------------------------
// status bit positions and reset values
// ---------------------------------------------------------------
`define ST_Z           0
`define ST_PWRDN       1
`define ST_TMOUT       2
`define STATUS_RST     3'h6
`define WDT_PRE_WRAP   8'hff

`endif

/* File: wdt_exec_pkg.sv */
// types shared by the instruction exec block
package wdt_exec_pkg;

	// ---------------------------------------------------------------
	// sequencer states and decoded operations
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		S_IDLE,
		S_MEMRD,
		S_EXEC
	} state_t;

	typedef enum logic [1:0]
	{
		OP_NONE,
		OP_WCLR,
		OP_CPL,
		OP_DEC
	} op_t;

endpackage

/* File: file_ram.sv */
// 128 x 8 file register memory with registered read data
`timescale 1ns/1ps

module file_ram
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// write port
	input  wire logic       we,
	input  wire logic [6:0] waddr,
	input  wire logic [7:0] wdata,
	// read port, data one cycle after re
	input  wire logic       re,
	input  wire logic [6:0] raddr,
	output logic      [7:0] rdata_r
);

	logic [7:0] mem [0:127];
	logic [7:0] rdata_nxt;

	// ---------------------------------------------------------------
	// read mux; data held when no read is asked
	// ---------------------------------------------------------------
	always_comb
	begin
		rdata_nxt = re ? mem[raddr] : rdata_r;
	end

	// array left unreset, like real file ram
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

endmodule

/* File: wdt_clear_complement_decrement_exec.sv */
// apb-driven exec of watchdog clear, complement and decrement
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "wdt_exec_defs.svh"

// Summary of operation
// - The watchdog clear opcode zeroes the watchdog counter and its prescaler in one cycle.
// - The watchdog clear opcode sets the time-out and power-down flags and keeps the zero flag.
// - The complement opcode inverts the addressed file byte and sets the zero flag from it.
// - For complement, destination 0 sends the result to the accumulator, 1 back to the file.
// - The decrement opcode subtracts one, sets the zero flag, and with destination 0 writes the accumulator.
// - For decrement, destination 1 writes the result back into the addressed file byte.
module wdt_clear_complement_decrement_exec
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// core status and watchdog side
	output logic             WDT_CLEAR,
	output logic             TIMEOUT_FLAG_N,
	output logic             POWERDOWN_FLAG_N
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	wdt_exec_pkg::state_t state_r, state_nxt;
	wdt_exec_pkg::op_t    op_r, op_nxt, op_dec;
	logic [13:0] instr_r, instr_nxt;
	logic [7:0]  w_r, w_nxt;
	logic [2:0]  status_r, status_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic        wclr_r, wclr_nxt;
	logic [7:0]  wdt_cnt_r, wdt_cnt_nxt;
	logic [7:0]  wdt_pre_r, wdt_pre_nxt;
	logic [7:0]  res;
	logic        access, in_file, launch;
	// file memory ports
	logic        mem_we, mem_re;
	logic [6:0]  mem_waddr, mem_raddr;
	logic [7:0]  mem_wdata, mem_rdata;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// full match for clear; upper six bits for the file ops
	function automatic wdt_exec_pkg::op_t decode(input logic [13:0] ins);
		decode = wdt_exec_pkg::OP_NONE;
		if (ins == `OP_WDT_CLR)
			decode = wdt_exec_pkg::OP_WCLR;
		else if (ins[`OPC_HI:`OPC_LO] == `OP_CPL_FILE)
			decode = wdt_exec_pkg::OP_CPL;
		else if (ins[`OPC_HI:`OPC_LO] == `OP_DEC_FILE)
			decode = wdt_exec_pkg::OP_DEC;
	endfunction

	// access phase not yet answered
	assign access  = PSEL && PENABLE && !pready_r;
	assign in_file = PADDR[`FILE_SEL_HI:`FILE_SEL_LO] == `FILE_SEL;
	assign launch  = state_r == wdt_exec_pkg::S_IDLE && access && PWRITE
		&& PADDR == `OFS_INSTR;
	assign op_dec  = decode(PWDATA[13:0]);

	file_ram u_ram
	(
		.clk     (CLK),
		.rst_n   (RST_N),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.re      (mem_re),
		.raddr   (mem_raddr),
		.rdata_r (mem_rdata)
	);

	// ---------------------------------------------------------------
	// bus and exec sequencer
	// ---------------------------------------------------------------
	// file ops hold the bus one extra cycle for the ram read
	always_comb
	begin
		state_nxt   = state_r;
		op_nxt      = op_r;
		instr_nxt   = instr_r;
		w_nxt       = w_r;
		status_nxt  = status_r;
		prdata_nxt  = prdata_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		wclr_nxt    = 1'b0;
		mem_we      = 1'b0;
		mem_waddr   = instr_r[`FADDR_HI:`FADDR_LO];
		mem_wdata   = 8'h00;
		mem_re      = 1'b0;
		mem_raddr   = PADDR[`FILE_IDX_HI:`FILE_IDX_LO];
		res         = 8'h00;
		case (state_r)
		wdt_exec_pkg::S_IDLE:
			if (access && in_file)
			begin
				if (PWRITE)
				begin
					mem_we     = 1'b1;
					mem_waddr  = PADDR[`FILE_IDX_HI:`FILE_IDX_LO];
					mem_wdata  = PWDATA[7:0];
					pready_nxt = 1'b1;
				end
				else
				begin
					mem_re    = 1'b1;
					state_nxt = wdt_exec_pkg::S_MEMRD;
				end
			end
			else if (access)
			begin
				pready_nxt = 1'b1;
				case (PADDR)
				`OFS_INSTR:
				begin
					prdata_nxt = {18'h00000, instr_r};
					if (PWRITE)
					begin
						instr_nxt = PWDATA[13:0];
						op_nxt    = op_dec;
						case (op_dec)
						wdt_exec_pkg::OP_WCLR:
						begin
							wclr_nxt            = 1'b1;
							status_nxt[`ST_TMOUT] = 1'b1;
							status_nxt[`ST_PWRDN] = 1'b1;
						end
						wdt_exec_pkg::OP_CPL,
						wdt_exec_pkg::OP_DEC:
						begin
							// fetch operand now, result next cycle
							mem_re     = 1'b1;
							mem_raddr  = PWDATA[`FADDR_HI:`FADDR_LO];
							pready_nxt = 1'b0;
							state_nxt  = wdt_exec_pkg::S_EXEC;
						end
						default:
							op_nxt = wdt_exec_pkg::OP_NONE;
						endcase
					end
				end
				`OFS_WREG:
				begin
					prdata_nxt = {24'h000000, w_r};
					if (PWRITE)
						w_nxt = PWDATA[7:0];
				end
				`OFS_STATUS:
				begin
					prdata_nxt = {29'h00000000, status_r};
					if (PWRITE)
						status_nxt = PWDATA[2:0];
				end
				`OFS_WDT:
					prdata_nxt = {16'h0000, wdt_pre_r, wdt_cnt_r};
				default:
				begin
					prdata_nxt  = 32'h00000000;
					pslverr_nxt = 1'b1;
				end
				endcase
			end
		wdt_exec_pkg::S_MEMRD:
		begin
			prdata_nxt = {24'h000000, mem_rdata};
			pready_nxt = 1'b1;
			state_nxt  = wdt_exec_pkg::S_IDLE;
		end
		wdt_exec_pkg::S_EXEC:
		begin
			if (op_r == wdt_exec_pkg::OP_CPL)
				res = ~mem_rdata;
			else
				res = mem_rdata - 8'h01;
			status_nxt[`ST_Z] = res == 8'h00;
			if (instr_r[`DEST_BIT])
			begin
				mem_we    = 1'b1;
				mem_wdata = res;
			end
			else
				w_nxt = res;
			pready_nxt = 1'b1;
			state_nxt  = wdt_exec_pkg::S_IDLE;
		end
		default:
			state_nxt = wdt_exec_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_r   <= wdt_exec_pkg::S_IDLE;
			op_r      <= wdt_exec_pkg::OP_NONE;
			instr_r   <= 14'h0000;
			w_r       <= 8'h00;
			status_r  <= `STATUS_RST;
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			wclr_r    <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			op_r      <= op_nxt;
			instr_r   <= instr_nxt;
			w_r       <= w_nxt;
			status_r  <= status_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			wclr_r    <= wclr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// watchdog counter and prescaler
	// ---------------------------------------------------------------
	// free-running stand-in; time-out detection lives elsewhere
	always_comb
	begin
		wdt_pre_nxt = wclr_nxt ? 8'h00 : wdt_pre_r + 8'h01;
		wdt_cnt_nxt = wdt_cnt_r;
		if (wclr_nxt)
			wdt_cnt_nxt = 8'h00;
		else if (wdt_pre_r == `WDT_PRE_WRAP)
			wdt_cnt_nxt = wdt_cnt_r + 8'h01;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wdt_pre_r <= 8'h00;
			wdt_cnt_r <= 8'h00;
		end
		else
		begin
			wdt_pre_r <= wdt_pre_nxt;
			wdt_cnt_r <= wdt_cnt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all straight from flops
	// ---------------------------------------------------------------
	assign PRDATA           = prdata_r;
	assign PREADY           = pready_r;
	assign PSLVERR          = pslverr_r;
	assign WDT_CLEAR        = wclr_r;
	assign TIMEOUT_FLAG_N   = status_r[`ST_TMOUT];
	assign POWERDOWN_FLAG_N = status_r[`ST_PWRDN];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_wclr_zero;
		@(posedge CLK) disable iff (!RST_N)
		launch && PWDATA[13:0] == `OP_WDT_CLR
		|=> wdt_cnt_r == 8'h00 && wdt_pre_r == 8'h00 && WDT_CLEAR && PREADY;
	endproperty
	a_wclr_zero: assert property (p_wclr_zero)
		else $error("watchdog clear did not zero counter");
	property p_wclr_flags;
		@(posedge CLK) disable iff (!RST_N)
		launch && PWDATA[13:0] == `OP_WDT_CLR
		|=> TIMEOUT_FLAG_N && POWERDOWN_FLAG_N
			&& status_r[`ST_Z] == $past(status_r[`ST_Z]);
	endproperty
	a_wclr_flags: assert property (p_wclr_flags)
		else $error("watchdog clear flags wrong");
	property p_cpl_zero;
		@(posedge CLK) disable iff (!RST_N)
		state_r == wdt_exec_pkg::S_EXEC && op_r == wdt_exec_pkg::OP_CPL
		|=> status_r[`ST_Z] == ($past(mem_rdata) == 8'hff);
	endproperty
	a_cpl_zero: assert property (p_cpl_zero)
		else $error("complement zero flag wrong");
	property p_cpl_dest;
		@(posedge CLK) disable iff (!RST_N)
		state_r == wdt_exec_pkg::S_EXEC && op_r == wdt_exec_pkg::OP_CPL
		|-> (instr_r[7] && mem_we && mem_wdata == ~mem_rdata)
			or (!instr_r[7] && !mem_we ##1 w_r == ~$past(mem_rdata));
	endproperty
	a_cpl_dest: assert property (p_cpl_dest)
		else $error("complement destination wrong");
	property p_dec_w;
		@(posedge CLK) disable iff (!RST_N)
		state_r == wdt_exec_pkg::S_EXEC && op_r == wdt_exec_pkg::OP_DEC
		&& !instr_r[7]
		|=> w_r == $past(mem_rdata) - 8'h01
			&& status_r[`ST_Z] == ($past(mem_rdata) == 8'h01);
	endproperty
	a_dec_w: assert property (p_dec_w)
		else $error("decrement to accumulator wrong");
	property p_dec_f;
		@(posedge CLK) disable iff (!RST_N)
		state_r == wdt_exec_pkg::S_EXEC && op_r == wdt_exec_pkg::OP_DEC
		&& instr_r[7]
		|-> mem_we && mem_wdata == mem_rdata - 8'h01
			&& mem_waddr == instr_r[6:0] ##1 $stable(w_r);
	endproperty
	a_dec_f: assert property (p_dec_f)
		else $error("decrement to file wrong");
	property p_file_addr;
		@(posedge CLK) disable iff (!RST_N)
		launch && (op_dec == wdt_exec_pkg::OP_CPL
			|| op_dec == wdt_exec_pkg::OP_DEC)
		|-> mem_re && mem_raddr == PWDATA[6:0]
			##1 state_r == wdt_exec_pkg::S_EXEC ##1 PREADY;
	endproperty
	a_file_addr: assert property (p_file_addr)
		else $error("file operand address wrong");
	property p_apb_answer;
		@(posedge CLK) disable iff (!RST_N)
		PSEL && PENABLE && !PREADY |-> ##[1:2] PREADY;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer late");

endmodule

/* File: wdt_clear_complement_decrement_exec_bench.sv */
// apb-driven bench for the watchdog clear, complement and decrement exec
`timescale 1ns/1ps

module wdt_clear_complement_decrement_exec_bench;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        CLK;
	logic        RST_N;
	logic        PSEL;
	logic        PENABLE;
	logic        PWRITE;
	logic [11:0] PADDR;
	logic [31:0] PWDATA;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        WDT_CLEAR;
	logic        TIMEOUT_FLAG_N;
	logic        POWERDOWN_FLAG_N;
	logic [31:0] rdata;
	logic        rerr;
	logic        clr;
	int          n_errors;
	int          n_checks;

	wdt_clear_complement_decrement_exec dut
	(
		.CLK              (CLK),
		.RST_N            (RST_N),
		.PSEL             (PSEL),
		.PENABLE          (PENABLE),
		.PWRITE           (PWRITE),
		.PADDR            (PADDR),
		.PWDATA           (PWDATA),
		.PRDATA           (PRDATA),
		.PREADY           (PREADY),
		.PSLVERR          (PSLVERR),
		.WDT_CLEAR        (WDT_CLEAR),
		.TIMEOUT_FLAG_N   (TIMEOUT_FLAG_N),
		.POWERDOWN_FLAG_N (POWERDOWN_FLAG_N)
	);

	// 200 MHz clock
	initial CLK = 1'b0;
	always #2.5 CLK = ~CLK;

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask

	// one apb transfer; answer taken at the edge that sees pready high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 20);
		rdata = PRDATA;
		rerr  = PSLVERR;
		clr   = WDT_CLEAR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		if (n >= 20)
			check("pready", 1'b0, 1'b1);
	endtask

	// file byte address from a 7-bit index
	function automatic logic [11:0] fa(input logic [6:0] f);
		return {3'h1, f, 2'h0};
	endfunction

	// opcode word: 6-bit opcode, destination, file address
	function automatic logic [31:0] op(input logic [5:0] o,
		input logic d, input logic [6:0] f);
		return {18'h0, o, d, f};
	endfunction

	// ---------------------------------------------------------------
	// watchdog: cuts a hang short
	// ---------------------------------------------------------------
	initial
	begin
		repeat (20000) @(posedge CLK);
		n_errors++;
		finish_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		n_errors = 0;
		n_checks = 0;
		RST_N    = 1'b0;
		PSEL     = 1'b0;
		PENABLE  = 1'b0;
		PWRITE   = 1'b0;
		PADDR    = 12'h000;
		PWDATA   = 32'h0;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		// reset values
		apb(0, 12'h008, 0);
		check("status rst", rdata, 32'h6);
		check("slverr ok", rerr, 1'b0);
		apb(0, 12'h004, 0);
		check("wreg rst", rdata, 32'h0);
		// accumulator write, bits above 7:0 dropped
		apb(1, 12'h004, 32'h1a5);
		apb(0, 12'h004, 0);
		check("wreg rw", rdata, 32'ha5);
		// complement to accumulator leaves the file byte alone
		apb(1, fa(7'h13), 32'h13);
		apb(1, 12'h000, op(6'h09, 0, 7'h13));
		check("clr cpl", clr, 1'b0);
		apb(0, 12'h004, 0);
		check("cpl w", rdata, 32'hec);
		apb(0, fa(7'h13), 0);
		check("cpl f kept", rdata, 32'h13);
		apb(0, 12'h008, 0);
		check("cpl z0", rdata, 32'h6);
		// complement back into the top file byte, zero result
		apb(1, fa(7'h7f), 32'hff);
		apb(1, 12'h000, op(6'h09, 1, 7'h7f));
		apb(0, fa(7'h7f), 0);
		check("cpl f", rdata, 32'h0);
		apb(0, 12'h004, 0);
		check("cpl w kept", rdata, 32'hec);
		apb(0, 12'h008, 0);
		check("cpl z1", rdata, 32'h7);
		// decrement into the file, one to zero
		apb(1, fa(7'h05), 32'h01);
		apb(1, 12'h000, op(6'h03, 1, 7'h05));
		apb(0, fa(7'h05), 0);
		check("dec f", rdata, 32'h0);
		apb(0, 12'h004, 0);
		check("dec w kept", rdata, 32'hec);
		apb(0, 12'h008, 0);
		check("dec z1", rdata, 32'h7);
		// decrement to accumulator, zero wraps to all ones
		apb(1, fa(7'h00), 32'h00);
		apb(1, 12'h000, op(6'h03, 0, 7'h00));
		apb(0, 12'h004, 0);
		check("dec w", rdata, 32'hff);
		apb(0, fa(7'h00), 0);
		check("dec f kept", rdata, 32'h0);
		apb(0, 12'h008, 0);
		check("dec z0", rdata, 32'h6);
		apb(0, fa(7'h13), 0);
		check("addr decode", rdata, 32'h13);
		// near-miss opcodes do nothing
		apb(1, 12'h000, 32'h0065);
		check("no clear", clr, 1'b0);
		apb(1, 12'h000, 32'h3fff);
		apb(0, 12'h004, 0);
		check("nop w", rdata, 32'hff);
		// watchdog clear: drop flags, let the counter run first
		apb(1, 12'h008, 32'h1);
		check("to low", TIMEOUT_FLAG_N, 1'b0);
		repeat (600) @(posedge CLK);
		apb(0, 12'h00c, 0);
		check("wdt ran", rdata[7:0] != 8'h0, 1'b1);
		apb(1, 12'h000, 32'h0064);
		check("clr pulse", clr, 1'b1);
		check("to set", TIMEOUT_FLAG_N, 1'b1);
		check("pd set", POWERDOWN_FLAG_N, 1'b1);
		apb(0, 12'h008, 0);
		check("status clr", rdata, 32'h7);
		// counter zero, prescaler only a few ticks since the clear
		apb(0, 12'h00c, 0);
		check("wdt zero", rdata[7:0] == 8'h0
			&& rdata[15:8] < 8'h10, 1'b1);
		// unmapped address
		apb(0, 12'h010, 0);
		check("slverr", rerr, 1'b1);
		check("slverr data", rdata, 32'h0);
		finish_test();
	end

endmodule
